/* File: common/wssw_pkg.sv */
// package for the world switch state swap block
// assumes one core clock and 4 KiB aligned save pages
package wssw_pkg;
	// ---------------------------------------------
	// widths and counts
	// ---------------------------------------------
	localparam int unsigned WSSW_DATA_W = 64;
	localparam int unsigned WSSW_ADDR_W = 64;
	localparam int unsigned WSSW_SLOT_W = 8;
	localparam int unsigned WSSW_OFF_W = 12;
	localparam logic [WSSW_SLOT_W-1:0] WSSW_LAST_SLOT = 8'hcd; // qword at 668h..66Fh
	localparam logic [WSSW_OFF_W-1:0] WSSW_GUEST_BASE = 12'h000;
	localparam logic [WSSW_OFF_W-1:0] WSSW_HOST_BASE = 12'h400;
	// ---------------------------------------------
	// save area byte offsets (qword granular)
	// ---------------------------------------------
	localparam logic [WSSW_OFF_W-1:0] OFF_SEG_A_END = 12'h03f;
	localparam logic [WSSW_OFF_W-1:0] OFF_FS = 12'h040;
	localparam logic [WSSW_OFF_W-1:0] OFF_GS_END = 12'h05f;
	localparam logic [WSSW_OFF_W-1:0] OFF_GDTR = 12'h060;
	localparam logic [WSSW_OFF_W-1:0] OFF_GDTR_END = 12'h06f;
	localparam logic [WSSW_OFF_W-1:0] OFF_LDTR = 12'h070;
	localparam logic [WSSW_OFF_W-1:0] OFF_LDTR_END = 12'h07f;
	localparam logic [WSSW_OFF_W-1:0] OFF_IDTR = 12'h080;
	localparam logic [WSSW_OFF_W-1:0] OFF_IDTR_END = 12'h08f;
	localparam logic [WSSW_OFF_W-1:0] OFF_TR = 12'h090;
	localparam logic [WSSW_OFF_W-1:0] OFF_TR_END = 12'h09f;
	localparam logic [WSSW_OFF_W-1:0] OFF_CPL_QW = 12'h0c8;
	localparam logic [7:0] BE_CPL = 8'h08; // only byte 0CBh
	localparam logic [WSSW_OFF_W-1:0] OFF_EFER = 12'h0d0;
	localparam logic [WSSW_OFF_W-1:0] OFF_CR4 = 12'h148;
	localparam logic [WSSW_OFF_W-1:0] OFF_RIP_END = 12'h17f;
	localparam logic [WSSW_OFF_W-1:0] OFF_STACK_PTR = 12'h1d8;
	localparam logic [WSSW_OFF_W-1:0] OFF_ACCUM = 12'h1f8;
	localparam logic [WSSW_OFF_W-1:0] OFF_STAR = 12'h200;
	localparam logic [WSSW_OFF_W-1:0] OFF_SYSENT_END = 12'h23f;
	localparam logic [WSSW_OFF_W-1:0] OFF_CR2 = 12'h240;
	localparam logic [WSSW_OFF_W-1:0] OFF_PAT = 12'h268;
	localparam logic [WSSW_OFF_W-1:0] OFF_DBGCTL = 12'h270;
	localparam logic [WSSW_OFF_W-1:0] OFF_LBR_END = 12'h297;
	localparam logic [WSSW_OFF_W-1:0] OFF_GPR_RSV0 = 12'h300;
	localparam logic [WSSW_OFF_W-1:0] OFF_GPR_LO = 12'h308;
	localparam logic [WSSW_OFF_W-1:0] OFF_GPR_RSV1 = 12'h320;
	localparam logic [WSSW_OFF_W-1:0] OFF_GPR_END = 12'h37f;
	localparam logic [WSSW_OFF_W-1:0] OFF_INTEG = 12'h380; // 16 bytes, device only
	localparam logic [WSSW_OFF_W-1:0] OFF_SOFT_CODE = 12'h390;
	localparam logic [WSSW_OFF_W-1:0] OFF_SOFT_SCR = 12'h3a8;
	localparam logic [WSSW_OFF_W-1:0] OFF_XCR0 = 12'h3e8;
	localparam logic [WSSW_OFF_W-1:0] OFF_VALID_VEC = 12'h3f0;
	localparam logic [WSSW_OFF_W-1:0] OFF_FP_DP = 12'h400;
	localparam logic [WSSW_OFF_W-1:0] OFF_FP_CTL = 12'h408;
	localparam logic [WSSW_OFF_W-1:0] OFF_FP_CW = 12'h410;
	localparam logic [WSSW_OFF_W-1:0] OFF_FP_STACK = 12'h420;
	localparam logic [WSSW_OFF_W-1:0] OFF_VEC_LO = 12'h470;
	localparam logic [WSSW_OFF_W-1:0] OFF_VEC_HI = 12'h570;
	localparam logic [WSSW_OFF_W-1:0] OFF_VEC_HI_END = 12'h66f;
	localparam logic [7:0] BE_ALL = 8'hff;
	// ---------------------------------------------
	// reset defaults for class C host values
	// ---------------------------------------------
	localparam logic [WSSW_DATA_W-1:0] DFLT_FP_CTL = 64'h0000_0000_0000_1f80;
	localparam logic [WSSW_DATA_W-1:0] DFLT_FP_CW = 64'h0000_0000_0000_037f;
	localparam logic [WSSW_DATA_W-1:0] DFLT_ZERO = 64'h0000_0000_0000_0000;
	// ---------------------------------------------
	// types
	// ---------------------------------------------
	typedef enum logic [2:0] {
		WSSW_CLS_NONE = 3'b000,
		WSSW_CLS_A = 3'b001,
		WSSW_CLS_B = 3'b010,
		WSSW_CLS_C = 3'b011,
		WSSW_CLS_GUEST = 3'b100
	} wssw_class_t;
	typedef enum logic [2:0] {
		WSSW_IDLE = 3'b000,
		WSSW_SCAN = 3'b001,
		WSSW_WRITE = 3'b010,
		WSSW_RDREQ = 3'b011,
		WSSW_RDDATA = 3'b100,
		WSSW_NEXT = 3'b101
	} wssw_state_t;
endpackage

/* File: common/wssw_slot_if.sv */
// slot lookup carrier between the sequencer and the classifier
// assumes the package is compiled first
interface wssw_slot_if;
	import wssw_pkg::*;
	logic [WSSW_SLOT_W-1:0] slot;
	wssw_class_t cls;
	logic [7:0] be;
	logic [WSSW_DATA_W-1:0] dflt;
	modport seq (output slot, input cls, be, dflt);
	modport cls_side (input slot, output cls, be, dflt);
endinterface

/* File: rtl/wssw_slot_class.sv */
// swap class, byte lanes and reset default of one save area qword
// assumes a purely combinational lookup on the slot index
module wssw_slot_class
	import wssw_pkg::*;
(
	wssw_slot_if.cls_side lk
);
	logic [WSSW_OFF_W-1:0] off;

	// byte offset of the qword
	assign off = {1'b0, lk.slot, 3'b000};

	// ---------------------------------------------
	// class decode
	// ---------------------------------------------
	always_comb begin
		lk.cls = WSSW_CLS_NONE;
		lk.be = BE_ALL;
		lk.dflt = DFLT_ZERO;
		if (off <= OFF_SEG_A_END) begin
			lk.cls = WSSW_CLS_A;
		end else if (off >= OFF_FS && off <= OFF_GS_END) begin
			lk.cls = WSSW_CLS_B;
		end else if (off >= OFF_GDTR && off <= OFF_GDTR_END) begin
			lk.cls = WSSW_CLS_A;
		end else if (off >= OFF_LDTR && off <= OFF_LDTR_END) begin
			lk.cls = WSSW_CLS_B;
		end else if (off >= OFF_IDTR && off <= OFF_IDTR_END) begin
			lk.cls = WSSW_CLS_A;
		end else if (off >= OFF_TR && off <= OFF_TR_END) begin
			lk.cls = WSSW_CLS_B;
		end else if (off == OFF_CPL_QW) begin
			lk.cls = WSSW_CLS_A;
			lk.be = BE_CPL; // neighbours are reserved
		end else if (off == OFF_EFER) begin
			lk.cls = WSSW_CLS_A;
		end else if (off >= OFF_CR4 && off <= OFF_RIP_END) begin
			lk.cls = WSSW_CLS_A;
		end else if (off == OFF_STACK_PTR || off == OFF_ACCUM) begin
			lk.cls = WSSW_CLS_A;
		end else if (off >= OFF_STAR && off <= OFF_SYSENT_END) begin
			lk.cls = WSSW_CLS_B;
		end else if (off == OFF_CR2) begin
			lk.cls = WSSW_CLS_C;
		end else if (off == OFF_PAT) begin
			lk.cls = WSSW_CLS_GUEST;
		end else if (off >= OFF_DBGCTL && off <= OFF_LBR_END) begin
			lk.cls = WSSW_CLS_A;
		end else if (off >= OFF_GPR_LO && off <= OFF_GPR_END && off != OFF_GPR_RSV1) begin
			lk.cls = WSSW_CLS_B; // 300h and 320h stay out
		end else if (off == OFF_XCR0) begin
			lk.cls = WSSW_CLS_B;
		end else if (off >= OFF_FP_DP && off <= OFF_VEC_HI_END) begin
			lk.cls = WSSW_CLS_C; // fp control, stack, vector halves
			if (off == OFF_FP_CTL) begin
				lk.dflt = DFLT_FP_CTL;
			end else if (off == OFF_FP_CW) begin
				lk.dflt = DFLT_FP_CW;
			end
		end
	end
endmodule

/* File: rtl/wssw_top.sv */
// world switch state swap sequencer
// assumes architectural state is read combinationally by slot index and
// memory answers a held request with a grant and read data later with rvalid
//
// Operation
// - with encrypted guest state mode on, the guest save structure starts at offset zero of the guest page.
// - class A items save host then load guest on entry, and save guest then load host on exit.
// - class B items only load guest on entry, and save guest then restore host on exit.
// - class C items only load guest on entry, and save guest then reset host to defaults on exit.
// - host state uses the same layout displaced to byte 400h of the host page.
// - soft exit code, the two soft exit info words and the soft scratch word are never touched.
// - the 16 bytes at 380h are kept for integrity checking and hold no swapped register.
// - the accumulator lives only at 1F8h and the stack pointer only at 1D8h, both class A.
// - the guest page attribute table is swapped for the guest only and never for the host.
// - the fp stack registers are an 80 byte class C field in stack order.
// - the wide vector upper halves are a 256 byte class C field after the lower vector field.
module wssw_top
	import wssw_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic encrypted_guest_state_mode_i,
	input wire logic guest_entry_instruction_i,
	input wire logic guest_exit_event_i,
	input wire logic [WSSW_ADDR_W-1:0] guest_page_i,
	input wire logic [WSSW_ADDR_W-1:0] host_page_i,
	output logic busy_o,
	output logic done_o,
	output logic [WSSW_SLOT_W-1:0] arch_idx_o,
	input wire logic [WSSW_DATA_W-1:0] arch_rdata_i,
	output logic arch_we_o,
	output logic [7:0] arch_be_o,
	output logic [WSSW_DATA_W-1:0] arch_wdata_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [WSSW_ADDR_W-1:0] mem_addr_o,
	output logic [7:0] mem_be_o,
	output logic [WSSW_DATA_W-1:0] mem_wdata_o,
	input wire logic mem_gnt_i,
	input wire logic mem_rvalid_i,
	input wire logic [WSSW_DATA_W-1:0] mem_rdata_i
);
	// class lookup carrier, driven from the slot register
	wssw_slot_if lk ();

	// ---------------------------------------------
	// sequencer state
	// ---------------------------------------------
	wssw_state_t state_reg, state_next;
	logic [WSSW_SLOT_W-1:0] slot_reg, slot_next;
	logic exit_reg, exit_next;
	logic done_reg, done_next;
	logic arch_we_reg, arch_we_next;
	logic [WSSW_DATA_W-1:0] arch_wdata_reg, arch_wdata_next;
	logic req_reg, req_next;
	logic we_reg, we_next;
	logic [WSSW_ADDR_W-1:0] addr_reg, addr_next;
	logic [WSSW_DATA_W-1:0] wdata_reg, wdata_next;
	logic [WSSW_OFF_W-1:0] off;
	logic [WSSW_ADDR_W-1:0] guest_addr, host_addr;

	// ---------------------------------------------
	// slot lookup
	// ---------------------------------------------
	wssw_slot_class u_class (
		.lk(lk)
	);
	assign lk.slot = slot_reg;
	assign off = {1'b0, slot_reg, 3'b000};

	// page addresses of the current qword
	assign guest_addr = {guest_page_i[WSSW_ADDR_W-1:WSSW_OFF_W], WSSW_GUEST_BASE + off};
	assign host_addr = {host_page_i[WSSW_ADDR_W-1:WSSW_OFF_W], WSSW_HOST_BASE + off};

	// ---------------------------------------------
	// sequencer next state
	// ---------------------------------------------
	always_comb begin
		state_next = state_reg;
		slot_next = slot_reg;
		exit_next = exit_reg;
		done_next = 1'b0;
		arch_we_next = 1'b0;
		arch_wdata_next = arch_wdata_reg;
		req_next = req_reg;
		we_next = we_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		case (state_reg)
			WSSW_IDLE: begin
				// switches outside the encrypted mode are not handled here
				if (encrypted_guest_state_mode_i &&
					(guest_entry_instruction_i || guest_exit_event_i)) begin
					exit_next = guest_exit_event_i;
					slot_next = '0;
					state_next = WSSW_SCAN;
				end
			end
			WSSW_SCAN: begin
				if (lk.cls == WSSW_CLS_NONE) begin
					// reserved, integrity and soft fields pass untouched
					state_next = WSSW_NEXT;
				end else if (!exit_reg && lk.cls == WSSW_CLS_A) begin
					// entry: host copy first
					req_next = 1'b1;
					we_next = 1'b1;
					addr_next = host_addr;
					wdata_next = arch_rdata_i;
					state_next = WSSW_WRITE;
				end else if (!exit_reg) begin
					// entry: guest load only
					req_next = 1'b1;
					we_next = 1'b0;
					addr_next = guest_addr;
					state_next = WSSW_RDREQ;
				end else begin
					// exit: guest copy first
					req_next = 1'b1;
					we_next = 1'b1;
					addr_next = guest_addr;
					wdata_next = arch_rdata_i;
					state_next = WSSW_WRITE;
				end
			end
			WSSW_WRITE: begin
				if (mem_gnt_i) begin
					req_next = 1'b0;
					if (!exit_reg) begin
						req_next = 1'b1;
						we_next = 1'b0;
						addr_next = guest_addr;
						state_next = WSSW_RDREQ;
					end else if (lk.cls == WSSW_CLS_A || lk.cls == WSSW_CLS_B) begin
						req_next = 1'b1;
						we_next = 1'b0;
						addr_next = host_addr;
						state_next = WSSW_RDREQ;
					end else if (lk.cls == WSSW_CLS_C) begin
						arch_we_next = 1'b1; // host takes reset value
						arch_wdata_next = lk.dflt;
						state_next = WSSW_NEXT;
					end else begin
						state_next = WSSW_NEXT; // no host value
					end
				end
			end
			WSSW_RDREQ: begin
				if (mem_gnt_i) begin
					req_next = 1'b0;
					state_next = WSSW_RDDATA;
				end
			end
			WSSW_RDDATA: begin
				if (mem_rvalid_i) begin
					arch_we_next = 1'b1;
					arch_wdata_next = mem_rdata_i;
					state_next = WSSW_NEXT;
				end
			end
			WSSW_NEXT: begin
				if (slot_reg == WSSW_LAST_SLOT) begin
					done_next = 1'b1;
					state_next = WSSW_IDLE;
				end else begin
					slot_next = slot_reg + 8'h01;
					state_next = WSSW_SCAN;
				end
			end
			default: begin
				state_next = WSSW_IDLE;
			end
		endcase
	end

	// ---------------------------------------------
	// sequencer registers
	// ---------------------------------------------
	// reset wins over the clock enable, so a held reset also clears a frozen block
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_reg <= WSSW_IDLE;
			slot_reg <= '0;
			exit_reg <= 1'b0;
			done_reg <= 1'b0;
			arch_we_reg <= 1'b0;
			arch_wdata_reg <= '0;
			req_reg <= 1'b0;
			we_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
		end else if (ce_i) begin
			state_reg <= state_next;
			slot_reg <= slot_next;
			exit_reg <= exit_next;
			done_reg <= done_next;
			arch_we_reg <= arch_we_next;
			arch_wdata_reg <= arch_wdata_next;
			req_reg <= req_next;
			we_reg <= we_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
		end
	end

	// outputs: strobes, data and requests come straight from registers
	assign busy_o = (state_reg != WSSW_IDLE);
	assign done_o = done_reg;
	assign arch_idx_o = slot_reg;
	// byte lanes are decoded from the slot register and stay put for a whole slot
	assign arch_be_o = lk.be;
	assign arch_we_o = arch_we_reg;
	assign arch_wdata_o = arch_wdata_reg;
	assign mem_req_o = req_reg;
	assign mem_we_o = we_reg;
	assign mem_addr_o = addr_reg;
	assign mem_be_o = lk.be; // only swapped bytes of the qword
	assign mem_wdata_o = wdata_reg;
endmodule

/* File: test/wssw_mem_model.sv */
// memory model holding the guest and host save pages
// assumes the sequencer holds each request until it sees the grant
module wssw_mem_model
	import wssw_pkg::*;
(
	input wire logic clock_i,
	input wire logic slow_i,
	input wire logic [WSSW_ADDR_W-1:0] guest_page_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [WSSW_ADDR_W-1:0] addr_i,
	input wire logic [7:0] be_i,
	input wire logic [WSSW_DATA_W-1:0] wdata_i,
	output logic gnt_o = 1'b0,
	output logic rvalid_o = 1'b0,
	output logic [WSSW_DATA_W-1:0] rdata_o = 64'h0f0f_0f0f_0f0f_0f0f
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WSSW_DATA_W-1:0] gmem [512];
	logic [WSSW_DATA_W-1:0] hmem [512];
	logic [8:0] ra;
	logic rg;
	logic rp = 1'b0;
	logic hit;
	int wcnt = 0;
	int rcnt = 0;
	assign hit = addr_i[63:12] == guest_page_i[63:12];
	// grant after a wait, store a write by lanes or queue a read
	always @(posedge clock_i) begin
		rvalid_o <= 1'b0;
		rdata_o <= ~rdata_o; // no valid data: lines keep moving
		if (req_i && gnt_o) begin
			gnt_o <= 1'b0;
			wcnt <= 0;
			for (int b = 0; b < 8; b++) begin
				if (we_i && be_i[b] && hit) gmem[addr_i[11:3]][b*8+:8] <= wdata_i[b*8+:8];
				if (we_i && be_i[b] && !hit) hmem[addr_i[11:3]][b*8+:8] <= wdata_i[b*8+:8];
			end
			rp <= !we_i;
			rg <= hit;
			ra <= addr_i[11:3];
			rcnt <= 0;
		end else if (req_i && wcnt >= (slow_i ? 3 : 0)) gnt_o <= 1'b1;
		else if (req_i) wcnt <= wcnt + 1;
		if (rp && rcnt >= (slow_i ? 4 : 0)) begin
			rp <= 1'b0;
			rvalid_o <= 1'b1;
			rdata_o <= rg ? gmem[ra] : hmem[ra];
		end else if (rp) rcnt <= rcnt + 1;
	end
endmodule

/* File: test/wssw_top_asserts.sv */
// checker on the swap sequencer ports
// assumes one clock domain, bound onto wssw_top
module wssw_top_asserts
	import wssw_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic encrypted_guest_state_mode_i,
	input wire logic guest_entry_instruction_i,
	input wire logic guest_exit_event_i,
	input wire logic [WSSW_ADDR_W-1:0] guest_page_i,
	input wire logic [WSSW_ADDR_W-1:0] host_page_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic arch_we_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [WSSW_ADDR_W-1:0] mem_addr_o,
	input wire logic [WSSW_DATA_W-1:0] mem_wdata_o,
	input wire logic mem_gnt_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic to_g;
	logic to_h;
	logic [WSSW_OFF_W-1:0] off;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	// page hit and save layout offset of a request
	assign to_g = mem_req_o && mem_addr_o[63:12] == guest_page_i[63:12];
	assign to_h = mem_req_o && mem_addr_o[63:12] == host_page_i[63:12];
	assign off = to_h ? mem_addr_o[11:0] - WSSW_HOST_BASE : mem_addr_o[11:0];
	sequence s_wait;
		mem_req_o && !mem_gnt_i;
	endsequence
	sequence s_held;
		mem_req_o && $stable(mem_we_o) && $stable(mem_addr_o) && $stable(mem_wdata_o);
	endsequence
	req_hold_a: assert property (s_wait |=> s_held)
		else $error("request moved before grant");
	busy_start_a: assert property ($rose(busy_o) |-> $past(encrypted_guest_state_mode_i) &&
		($past(guest_entry_instruction_i) || $past(guest_exit_event_i)))
		else $error("busy without command");
	done_pulse_a: assert property (done_o |-> !busy_o ##1 !done_o)
		else $error("done not a lone pulse");
	freeze_hold_a: assert property (!ce_i |=> $stable(busy_o) && $stable(mem_req_o) &&
		$stable(done_o) && $stable(arch_we_o) && $stable(mem_addr_o))
		else $error("state moved while clock enable low");
	arch_busy_a: assert property (arch_we_o |-> busy_o)
		else $error("arch write while idle");
	page_hit_a: assert property (mem_req_o |-> (to_g || to_h) && mem_addr_o[2:0] == 3'h0)
		else $error("request off the save pages");
	guest_span_a: assert property (to_g |-> off <= OFF_VEC_HI_END)
		else $error("guest offset past end");
	host_span_a: assert property (to_h |-> mem_addr_o[11:0] >= WSSW_HOST_BASE)
		else $error("host access below host base");
	integ_skip_a: assert property (mem_req_o |-> off[11:4] != OFF_INTEG[11:4])
		else $error("integrity area touched");
	soft_skip_a: assert property (mem_req_o |-> !(off inside {[OFF_SOFT_CODE:OFF_SOFT_SCR]}))
		else $error("soft exit field touched");
	gpr_gap_a: assert property (mem_req_o |-> off != OFF_GPR_RSV0 && off != OFF_GPR_RSV1)
		else $error("reserved register slot touched");
	pat_host_a: assert property (to_h |-> off != OFF_PAT)
		else $error("host page attr slot touched");
	resv_skip_a: assert property (mem_req_o |-> !(off inside {[12'h0a0:12'h0c7],
		[12'h0d8:12'h147], [12'h180:12'h1d7], [12'h248:12'h267], [12'h298:12'h2ff],
		[12'h3b0:12'h3e7], [12'h3f0:12'h3ff]}))
		else $error("reserved range touched");
endmodule
bind wssw_top wssw_top_asserts chk (.clock_i, .rst_n_i, .ce_i, .encrypted_guest_state_mode_i,
	.guest_entry_instruction_i, .guest_exit_event_i, .guest_page_i, .host_page_i, .busy_o,
	.done_o, .arch_we_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_gnt_i);

/* File: test/world_switch_state_swap_tb_top.sv */
// self-checking bench for the swap sequencer
// assumes the memory model and checker are compiled first
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module world_switch_state_swap_tb_top
	import wssw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic encrypted_guest_state_mode_i = 1'b1;
	logic guest_entry_instruction_i = 1'b0;
	logic guest_exit_event_i = 1'b0;
	logic slow = 1'b0;
	logic ce = 1'b1;
	logic [63:0] guest_page_i = 64'h0000_0000_0001_0000;
	logic [63:0] host_page_i = 64'h0000_0000_0002_0000;
	logic busy_o, done_o, arch_we_o, mem_req_o, mem_we_o, mem_gnt_i, mem_rvalid_i;
	logic [7:0] arch_idx_o, arch_be_o, mem_be_o;
	logic [63:0] arch_rdata_i, arch_wdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic [63:0] arch [256];
	logic [63:0] ea [256];
	logic [63:0] eg [512];
	logic [63:0] eh [512];
	int err_total = 0;
	int n_compared = 0;
	always #20 clock_i = ~clock_i;
	// architectural state answers by slot and takes writes by lanes
	assign arch_rdata_i = arch[arch_idx_o];
	always @(posedge clock_i)
		if (arch_we_o)
			for (int b = 0; b < 8; b++)
				if (arch_be_o[b]) arch[arch_idx_o][b*8+:8] <= arch_wdata_o[b*8+:8];
	wssw_mem_model mem (.clock_i, .slow_i(slow), .guest_page_i, .req_i(mem_req_o),
		.we_i(mem_we_o), .addr_i(mem_addr_o), .be_i(mem_be_o), .wdata_i(mem_wdata_o),
		.gnt_o(mem_gnt_i), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
	wssw_top uut (.clock_i, .rst_n_i, .ce_i(ce), .encrypted_guest_state_mode_i,
		.guest_entry_instruction_i, .guest_exit_event_i, .guest_page_i, .host_page_i, .busy_o,
		.done_o, .arch_idx_o, .arch_rdata_i, .arch_we_o, .arch_be_o, .arch_wdata_o, .mem_req_o,
		.mem_we_o, .mem_addr_o, .mem_be_o, .mem_wdata_o, .mem_gnt_i, .mem_rvalid_i, .mem_rdata_i);
	// ---------------------------------------------
	// expectation helpers
	// ---------------------------------------------
	function automatic int cls(input int o);
		if (o inside {[12'h000:12'h03f], [12'h060:12'h06f], [12'h080:12'h08f], 12'h0c8, 12'h0d0,
			[12'h148:12'h17f], 12'h1d8, 12'h1f8, [12'h270:12'h297]}) return 1;
		if (o inside {[12'h040:12'h05f], [12'h070:12'h07f], [12'h090:12'h09f], [12'h200:12'h23f],
			[12'h308:12'h318], [12'h328:12'h37f], 12'h3e8}) return 2;
		if (o inside {12'h240, [12'h400:12'h66f]}) return 3;
		return (o == 12'h268) ? 4 : 0;
	endfunction
	task automatic exp_run(input bit ex);
		int k;
		logic [63:0] m;
		logic [63:0] a;
		for (int s = 0; s <= 8'hcd; s++) begin
			k = cls(s * 8);
			m = (s == 8'h19) ? 64'h0000_0000_ff00_0000 : '1;
			a = ea[s];
			if (!ex && k == 1) eh[s + 'h80] = (eh[s + 'h80] & ~m) | (a & m);
			if (!ex && k != 0) ea[s] = (a & ~m) | (eg[s] & m);
			if (ex && k != 0) eg[s] = (eg[s] & ~m) | (a & m);
			if (ex && k < 3 && k != 0) ea[s] = (a & ~m) | (eh[s + 'h80] & m);
			if (ex && k == 3) ea[s] = (s == 8'h81) ? DFLT_FP_CTL :
				(s == 8'h82) ? DFLT_FP_CW : DFLT_ZERO;
		end
	endtask
	task automatic fill();
		for (int i = 0; i < 512; i++) begin
			mem.gmem[i] = {32'h6a6a_0000, 23'h0, i[8:0]}; // validity vector seeded too
			mem.hmem[i] = {32'h5c5c_0000, 23'h0, i[8:0]};
			eg[i] = mem.gmem[i];
			eh[i] = mem.hmem[i];
			if (i < 256) arch[i] = {32'h3b3b_0000, 23'h0, i[8:0]};
			if (i < 256) ea[i] = arch[i];
		end
	endtask
	task automatic compare();
		for (int i = 0; i < 512; i++) begin
			if (i < 256) `CHK("arch", ea[i], arch[i])
			`CHK("guest page", eg[i], mem.gmem[i])
			`CHK("host page", eh[i], mem.hmem[i])
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// wait for the done pulse, bounded; a missing pulse ends the run
	task automatic wait_done();
		int n;
		n = 0;
		while (done_o !== 1'b1 && n < 5000) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		if (done_o !== 1'b1) err_total++;
		if (done_o !== 1'b1) wrap_up();
	endtask
	// issue a command and wait for its done pulse
	task automatic go(input logic en, input logic ex);
		guest_entry_instruction_i = en;
		guest_exit_event_i = ex;
		@(posedge clock_i);
		#1;
		guest_entry_instruction_i = 1'b0;
		guest_exit_event_i = 1'b0;
		`CHK("busy", 1'b1, busy_o)
		wait_done();
	endtask
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic t_swap();
		fill();
		go(1'b1, 1'b0);
		exp_run(1'b0);
		compare();
		slow = 1'b1; // exit given in the done cycle, slow memory
		go(1'b0, 1'b1);
		exp_run(1'b1);
		compare();
	endtask
	task automatic t_mode_off();
		fill();
		encrypted_guest_state_mode_i = 1'b0;
		guest_entry_instruction_i = 1'b1;
		repeat (3) begin
			@(posedge clock_i);
			#1;
			`CHK("busy", 1'b0, busy_o)
		end
		guest_entry_instruction_i = 1'b0;
		encrypted_guest_state_mode_i = 1'b1;
		compare();
	endtask
	task automatic t_both();
		fill();
		slow = 1'b0;
		go(1'b1, 1'b1);
		exp_run(1'b1);
		compare();
	endtask
	// clock enable low right after an entry command: no request may start
	task automatic t_freeze();
		fill();
		guest_entry_instruction_i = 1'b1;
		@(posedge clock_i);
		#1;
		guest_entry_instruction_i = 1'b0;
		ce = 1'b0;
		repeat (3) begin
			@(posedge clock_i);
			#1;
			`CHK("frozen busy", 1'b1, busy_o)
			`CHK("frozen req", 1'b0, mem_req_o)
		end
		ce = 1'b1;
		wait_done();
		exp_run(1'b0);
		compare();
	endtask
	initial begin
		repeat (16) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		t_swap();
		t_mode_off();
		t_both();
		t_freeze();
		wrap_up();
	end
endmodule
